// ===== src/dst_edge.v
// polarity-qualified edge detector for a synchronous pin
`timescale 1ns/1ps
module dst_edge
(
    input wire clk,
    input wire rstn,
    input wire pin,
    input wire rising,
    output wire edge_o
);
    reg prev_q;

    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            prev_q <= 1'b0;
        else
            prev_q <= pin;
    end

    // rising chooses low-to-high, otherwise high-to-low
    assign edge_o = rising ? (pin & ~prev_q) : (~pin & prev_q);
endmodule

// ===== src/dst_map.vh
// register map, fields, codes and reset values of the dual timer
// What this block does
// - timer clock is system clock divided by prescale field plus one, 1 to 32
// - prescale register clears on reset, timer clock equals system clock
// - counter 1 clock: off, prescaled, pin B events, pulse accumulate, slow clock
// - counter 2 clock select uses the same five codes in bits 5 to 3
// - clock select clears on reset, both counters stopped
// - counters and reload/capture registers keep contents through reset
// - two-bit mode field selects modes 1 to 4; mode register clears on reset
// - pin A polarity zero means falling edge acts, one means rising edge
// - pin B polarity zero means falling edge acts, one means rising edge
// - pulse accumulate counts only while pin B level equals its polarity bit
// - mode 2 with pin A enable: pin A edge presets counter 1 to all ones
// - modes 1, 3, 4 with pin A enable: pin A toggles on counter 1 underflow
// - pin B enable: edge presets counter 1 in mode 2, counter 2 in mode 4
// - pin B enable has no effect in modes 1 and 3
// - pin A output bit holds pin level, hardware toggles it, software reads/writes
// - software write to pin A output bit beats a coincident hardware toggle
// - four pending flags set by hardware or software one; zero ignored; reset clears
// - enable bits gate pending flags onto interrupts; flags set regardless
// - clear register bit one clears matching pending flag; zero leaves it
// - clear register is write-only, byte wide, upper four bits reserved
// - sources A, B, C drive first interrupt; source D drives second
// - mode 4: counter 2 on pin B event or accumulate clocking stops
`ifndef DST_MAP_VH
`define DST_MAP_VH

`define DST_OFS_PRESCALE 6'h00
`define DST_OFS_CLKSEL 6'h04
`define DST_OFS_CNT1 6'h08
`define DST_OFS_CNT2 6'h0C
`define DST_OFS_RCAP1 6'h10
`define DST_OFS_RCAP2 6'h14
`define DST_OFS_MODE 6'h18
`define DST_OFS_INTCTL 6'h1C
`define DST_OFS_INTCLR 6'h20

`define DST_PRESCALE_RST 5'h00
`define DST_CLKSEL_RST 6'h00
`define DST_MODE_RST 7'h00
`define DST_INTCTL_RST 8'h00

// clock select codes
`define DST_CS_OFF 3'h0
`define DST_CS_PRESC 3'h1
`define DST_CS_EVENT 3'h2
`define DST_CS_ACCUM 3'h3
`define DST_CS_SLOW 3'h4

// mode codes
`define DST_M1 2'h0
`define DST_M2 2'h1
`define DST_M3 2'h2
`define DST_M4 2'h3

// mode control field positions
`define DST_MODE_LO 0
`define DST_MODE_HI 1
`define DST_A_POL 2
`define DST_B_POL 3
`define DST_A_EN 4
`define DST_B_EN 5
`define DST_A_OUT 6

`define DST_PRESET 16'hFFFF
`define DST_RESP_OKAY 2'h0
`define DST_RESP_SLVERR 2'h2

`endif

// ===== src/dst_timer.v
// dual 16-bit timer/counter with its registers behind an axi4-lite slave
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "dst_map.vh"
module dst_timer
(
    input wire clk,
    input wire rstn,
    input wire [5:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [5:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire timer_pin_a_i,
    output reg timer_pin_a_o,
    output reg timer_pin_a_oe,
    input wire timer_pin_b_i,
    input wire slow_clk_i,
    output reg timer_irq1,
    output reg timer_irq2
);
    reg [4:0] prescale_divisor_field_q;
    reg [5:0] clk_sel_q;
    reg [6:0] mode_ctl_q;
    reg [7:0] int_ctl_q;
    reg [4:0] ps_cnt_q;
    reg pwm_phase_q;
    reg [15:0] first_counter_q, first_counter_d;
    reg [15:0] second_counter_q, second_counter_d;
    reg [15:0] first_reload_capture_q, first_reload_capture_d;
    reg [15:0] second_reload_capture_q, second_reload_capture_d;
    reg [3:0] pend_d;
    reg aout_d;
    reg aw_held_q, w_held_q;
    reg [5:0] waddr_q;
    reg [31:0] wdata_q;
    reg [3:0] wstrb_q;
    reg slow_s1_q, slow_s2_q;

    wire [1:0] mode = mode_ctl_q[`DST_MODE_HI:`DST_MODE_LO];
    wire a_pol = mode_ctl_q[`DST_A_POL];
    wire b_pol = mode_ctl_q[`DST_B_POL];
    wire a_en = mode_ctl_q[`DST_A_EN];
    wire b_en = mode_ctl_q[`DST_B_EN];
    wire aout = mode_ctl_q[`DST_A_OUT];
    wire a_edge, b_edge, slow_pulse;

    // write strobe per register once address and data are both held
    wire do_wr = aw_held_q & w_held_q & ~s_axi_bvalid;
    wire wr_mapped = (waddr_q <= `DST_OFS_INTCLR) && (waddr_q[1:0] == 2'h0);
    wire wr_psc = do_wr && (waddr_q == `DST_OFS_PRESCALE) && wstrb_q[0];
    wire wr_cs = do_wr && (waddr_q == `DST_OFS_CLKSEL) && wstrb_q[0];
    wire wr_c1 = do_wr && (waddr_q == `DST_OFS_CNT1);
    wire wr_c2 = do_wr && (waddr_q == `DST_OFS_CNT2);
    wire wr_r1 = do_wr && (waddr_q == `DST_OFS_RCAP1);
    wire wr_r2 = do_wr && (waddr_q == `DST_OFS_RCAP2);
    wire wr_md = do_wr && (waddr_q == `DST_OFS_MODE) && wstrb_q[0];
    wire wr_ic = do_wr && (waddr_q == `DST_OFS_INTCTL) && wstrb_q[0];
    wire wr_clr = do_wr && (waddr_q == `DST_OFS_INTCLR) && wstrb_q[0];

    // byte-lane merge for the 16-bit registers
    function [15:0] merge16;
        input [15:0] old;
        input [31:0] data;
        input [3:0] strb;
        begin
            merge16 = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
        end
    endfunction

    // count enable for one counter from its clock select
    function clk_en;
        input [2:0] sel;
        input tick;
        input ev;
        input lvl_ok;
        input slow;
        begin
            case (sel)
                `DST_CS_PRESC: clk_en = tick;
                `DST_CS_EVENT: clk_en = ev;
                `DST_CS_ACCUM: clk_en = tick & lvl_ok;
                `DST_CS_SLOW: clk_en = slow;
                default: clk_en = 1'b0;
            endcase
        end
    endfunction

    dst_edge u_edge_a
    (
        .clk(clk),
        .rstn(rstn),
        .pin(timer_pin_a_i),
        .rising(a_pol),
        .edge_o(a_edge)
    );

    dst_edge u_edge_b
    (
        .clk(clk),
        .rstn(rstn),
        .pin(timer_pin_b_i),
        .rising(b_pol),
        .edge_o(b_edge)
    );

    // edge detector reads only the second synchroniser stage
    dst_edge u_edge_slow
    (
        .clk(clk),
        .rstn(rstn),
        .pin(slow_s2_q),
        .rising(1'b1),
        .edge_o(slow_pulse)
    );

    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            slow_s1_q <= 1'b0;
            slow_s2_q <= 1'b0;
        end
        else
        begin
            slow_s1_q <= slow_clk_i;
            slow_s2_q <= slow_s1_q;
        end
    end

    // prescaler; >= covers a divisor lowered below the running count
    wire tick = (ps_cnt_q >= prescale_divisor_field_q);

    wire lvl_ok = (timer_pin_b_i == b_pol);
    wire [2:0] sel1 = clk_sel_q[2:0];
    wire [2:0] sel2 = clk_sel_q[5:3];
    wire cen1 = clk_en(sel1, tick, b_edge, lvl_ok, slow_pulse);
    // pin B is the capture input in mode 4
    wire sel2_pin = (sel2 == `DST_CS_EVENT) || (sel2 == `DST_CS_ACCUM);
    wire cen2 = clk_en(sel2, tick, b_edge, lvl_ok, slow_pulse) &
                ~((mode == `DST_M4) & sel2_pin);
    wire uf1 = cen1 & (first_counter_q == 16'h0000);
    wire uf2 = cen2 & (second_counter_q == 16'h0000);
    wire a_cap = a_edge & (mode == `DST_M2);
    wire b_cap = b_edge & ((mode == `DST_M2) | (mode == `DST_M4));
    // pin B enable only acts in modes 2 and 4 via b_cap
    wire b_pre = b_cap & b_en;
    wire a_out_mode = (mode != `DST_M2);
    wire toggle = uf1 & a_en & a_out_mode;
    wire [3:0] hw_set;

    assign hw_set[0] = (mode == `DST_M2) ? a_cap : (uf1 & ((mode != `DST_M1) | ~pwm_phase_q));
    assign hw_set[1] = b_cap | ((mode == `DST_M1) & uf1 & pwm_phase_q);
    assign hw_set[2] = (mode == `DST_M2) & uf1;
    assign hw_set[3] = uf2;

    always @*
    begin
        first_counter_d = first_counter_q;
        if (cen1)
        begin
            if (first_counter_q != 16'h0000)
                first_counter_d = first_counter_q - 16'h0001;
            else if (mode == `DST_M2)
                first_counter_d = `DST_PRESET;
            else if ((mode == `DST_M1) & pwm_phase_q)
                first_counter_d = second_reload_capture_q;
            else
                first_counter_d = first_reload_capture_q;
        end
        if ((a_cap & a_en) | (b_pre & (mode == `DST_M2)))
            first_counter_d = `DST_PRESET;
        if (wr_c1)
            first_counter_d = merge16(first_counter_q, wdata_q, wstrb_q);

        second_counter_d = second_counter_q;
        if (cen2)
        begin
            if ((second_counter_q == 16'h0000) & (mode == `DST_M3))
                second_counter_d = second_reload_capture_q;
            else
                second_counter_d = second_counter_q - 16'h0001;
        end
        if (b_pre & (mode == `DST_M4))
            second_counter_d = `DST_PRESET;
        if (wr_c2)
            second_counter_d = merge16(second_counter_q, wdata_q, wstrb_q);

        first_reload_capture_d = first_reload_capture_q;
        if (a_cap)
            first_reload_capture_d = first_counter_q;
        if (wr_r1)
            first_reload_capture_d = merge16(first_reload_capture_q, wdata_q, wstrb_q);

        second_reload_capture_d = second_reload_capture_q;
        if (b_cap)
            second_reload_capture_d = (mode == `DST_M2) ? first_counter_q : second_counter_q;
        if (wr_r2)
            second_reload_capture_d = merge16(second_reload_capture_q, wdata_q, wstrb_q);

        // clear first, then hardware and software sets win
        pend_d = int_ctl_q[3:0];
        if (wr_clr)
            pend_d = pend_d & ~wdata_q[3:0];
        pend_d = pend_d | hw_set;
        if (wr_ic)
            pend_d = pend_d | wdata_q[3:0];

        aout_d = toggle ? ~aout : aout;
        if (wr_md)
            aout_d = wdata_q[`DST_A_OUT];
    end

    // no reset here: contents survive reset
    always @(posedge clk)
    begin
        first_counter_q <= first_counter_d;
        second_counter_q <= second_counter_d;
        first_reload_capture_q <= first_reload_capture_d;
        second_reload_capture_q <= second_reload_capture_d;
    end

    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            prescale_divisor_field_q <= `DST_PRESCALE_RST;
            clk_sel_q <= `DST_CLKSEL_RST;
            mode_ctl_q <= `DST_MODE_RST;
            int_ctl_q <= `DST_INTCTL_RST;
            ps_cnt_q <= 5'h00;
            pwm_phase_q <= 1'b0;
            timer_pin_a_o <= 1'b0;
            timer_pin_a_oe <= 1'b0;
            timer_irq1 <= 1'b0;
            timer_irq2 <= 1'b0;
        end
        else
        begin
            ps_cnt_q <= tick ? 5'h00 : ps_cnt_q + 5'h01;
            if (wr_psc)
                prescale_divisor_field_q <= wdata_q[4:0];
            if (wr_cs)
                clk_sel_q <= wdata_q[5:0];
            if (wr_md)
                mode_ctl_q[5:0] <= wdata_q[5:0];
            mode_ctl_q[`DST_A_OUT] <= aout_d;
            if ((mode == `DST_M1) & uf1)
                pwm_phase_q <= ~pwm_phase_q;
            else if (mode != `DST_M1)
                pwm_phase_q <= 1'b0;
            int_ctl_q[3:0] <= pend_d;
            if (wr_ic)
                int_ctl_q[7:4] <= wdata_q[7:4];
            // pin level follows the output bit; driven only with pin A enable outside mode 2
            timer_pin_a_o <= aout_d;
            timer_pin_a_oe <= a_en & a_out_mode;
            // one cycle behind the pending flags
            timer_irq1 <= |(int_ctl_q[2:0] & int_ctl_q[6:4]);
            timer_irq2 <= int_ctl_q[3] & int_ctl_q[7];
        end
    end

    // axi4-lite write channel: address and data taken in either order
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `DST_RESP_OKAY;
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            waddr_q <= 6'h00;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid & s_axi_awready)
            begin
                aw_held_q <= 1'b1;
                waddr_q <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid & s_axi_wready)
            begin
                w_held_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_wr)
            begin
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_mapped ? `DST_RESP_OKAY : `DST_RESP_SLVERR;
            end
            // ready again only after the response is taken
            if (s_axi_bvalid & s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // axi4-lite read channel; the clear register reads as zero
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `DST_RESP_OKAY;
        end
        else if (s_axi_arvalid & s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `DST_RESP_OKAY;
            case (s_axi_araddr)
                `DST_OFS_PRESCALE: s_axi_rdata <= {27'h0000000, prescale_divisor_field_q};
                `DST_OFS_CLKSEL: s_axi_rdata <= {26'h0000000, clk_sel_q};
                `DST_OFS_CNT1: s_axi_rdata <= {16'h0000, first_counter_q};
                `DST_OFS_CNT2: s_axi_rdata <= {16'h0000, second_counter_q};
                `DST_OFS_RCAP1: s_axi_rdata <= {16'h0000, first_reload_capture_q};
                `DST_OFS_RCAP2: s_axi_rdata <= {16'h0000, second_reload_capture_q};
                `DST_OFS_MODE: s_axi_rdata <= {25'h0000000, mode_ctl_q};
                `DST_OFS_INTCTL: s_axi_rdata <= {24'h000000, int_ctl_q};
                `DST_OFS_INTCLR: s_axi_rdata <= 32'h00000000;
                default:
                begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= `DST_RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rvalid & s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
endmodule

// ===== test/dst_pins.sv
// pin-side partner: resolves pin A and drives pin B
`timescale 1ns/1ps
module dst_pins
(
    input wire pa_o,
    input wire pa_oe,
    input wire a_lvl,
    input wire b_lvl,
    output wire pin_a,
    output wire pin_b
);
    // timer drive wins while enabled, else the outside source
    assign pin_a = pa_oe ? pa_o : a_lvl;
    assign pin_b = b_lvl;
endmodule

// ===== test/dst_timer_chk.sv
// port-level assertions for the dual timer
`timescale 1ns/1ps
`include "dst_map.vh"
module dst_timer_chk
(
    input wire clk,
    input wire rstn,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [5:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire timer_irq1,
    input wire timer_irq2,
    input wire timer_pin_a_oe
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_wr_answer: assert property (s_wr_take |=> !s_axi_awready && !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write answer not two cycles after take");
    a_rd_answer: assert property (s_rd_take |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer not one cycle after take");
    a_aw_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while answer pending");
    a_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
        else $error("write answer not released");
    a_r_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
        else $error("read answer not released");
    a_clr_reads_zero: assert property (
        s_rd_take ##0 (s_axi_araddr == `DST_OFS_INTCLR) |=> s_axi_rdata == 32'h0)
        else $error("clear register read not zero");
    a_unmapped_err: assert property (s_rd_take ##0 (s_axi_araddr == 6'h24)
        |=> s_axi_rresp == `DST_RESP_SLVERR)
        else $error("unmapped read not refused");
    a_reset_quiet: assert property (
        $rose(rstn) |-> !timer_irq1 && !timer_irq2 && !timer_pin_a_oe)
        else $error("outputs active right after reset");
endmodule
bind dst_timer dst_timer_chk i_dst_timer_chk (.clk(clk), .rstn(rstn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .timer_irq1(timer_irq1),
    .timer_irq2(timer_irq2), .timer_pin_a_oe(timer_pin_a_oe));

// ===== test/tb_dst_timer.sv
// register-level bench of the dual timer
`timescale 1ns/1ps
`include "dst_map.vh"
module tb_dst_timer;
    reg clk = 1'b0;
    reg rstn = 1'b0;
    reg [5:0] awaddr = 6'h0;
    reg [5:0] araddr = 6'h0;
    reg [31:0] wdata = 32'h0;
    reg awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0, rrdy = 1'b0;
    reg a_lvl = 1'b0, b_lvl = 1'b0, slow = 1'b0, pa_prev;
    wire awr, wr_r, bv, arr, rvd, pa_o, pa_oe, pin_a, pin_b, irq1, irq2;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    reg [31:0] rv;
    reg [1:0] rr;
    integer n_errors = 0, check_count = 0, tg, t0;
    dst_timer i_dst_timer (.clk(clk), .rstn(rstn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
        .s_axi_bready(brdy), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvd),
        .s_axi_rready(rrdy), .timer_pin_a_i(pin_a), .timer_pin_a_o(pa_o),
        .timer_pin_a_oe(pa_oe), .timer_pin_b_i(pin_b), .slow_clk_i(slow),
        .timer_irq1(irq1), .timer_irq2(irq2));
    dst_pins i_dst_pins (.pa_o(pa_o), .pa_oe(pa_oe), .a_lvl(a_lvl), .b_lvl(b_lvl),
        .pin_a(pin_a), .pin_b(pin_b));
    initial forever #50 clk = ~clk;
    task complete_run;
    begin
        if (n_errors == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    end
    endtask
    task chk(input [31:0] g, input [31:0] e);
    begin
        check_count = check_count + 1;
        if (g !== e)
        begin
            n_errors = n_errors + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    end
    endtask
    task wr(input [5:0] a, input [31:0] d);
    begin
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        brdy <= 1'b1;
        do
        begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wr_r) wv <= 1'b0;
        end while (!bv);
        rr = bresp;
        brdy <= 1'b0;
    end
    endtask
    task rd(input [5:0] a);
    begin
        @(posedge clk);
        araddr <= a;
        arv <= 1'b1;
        rrdy <= 1'b1;
        do
        begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
        end while (!rvd);
        rv = rdata;
        rr = rresp;
        rrdy <= 1'b0;
    end
    endtask
    task rdc(input [5:0] a, input [31:0] e);
    begin
        rd(a);
        chk(rv, e);
    end
    endtask
    // level change, then time for the synchronous edge detector to act
    task pin(input s, input l);
    begin
        @(posedge clk);
        if (s) b_lvl <= l;
        else a_lvl <= l;
        repeat (3) @(posedge clk);
    end
    endtask
    // settle two cycles so a toggle launched by the last write is not counted
    task tog(input integer n);
    begin
        repeat (2) @(posedge clk);
        tg = 0;
        pa_prev = pa_o;
        repeat (n)
        begin
            @(posedge clk);
            if (pa_o !== pa_prev) tg = tg + 1;
            pa_prev = pa_o;
        end
    end
    endtask
    // ample margin over the roughly 650 cycles the sequence needs
    initial
    begin
        #400000;
        n_errors = n_errors + 1;
        complete_run;
    end
    initial
    begin
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        rdc(`DST_OFS_PRESCALE, 32'h0);
        rdc(`DST_OFS_CLKSEL, 32'h0);
        rdc(`DST_OFS_MODE, 32'h0);
        rdc(`DST_OFS_INTCTL, 32'h0);
        rdc(`DST_OFS_INTCLR, 32'h0);
        rd(6'h24);
        chk(rr, `DST_RESP_SLVERR);
        wr(6'h24, 32'hFF);
        chk(rr, `DST_RESP_SLVERR);
        wr(`DST_OFS_PRESCALE, 32'hFF);
        rdc(`DST_OFS_PRESCALE, 32'h1F);
        wr(`DST_OFS_INTCTL, 32'h05);
        wr(`DST_OFS_INTCTL, 32'h00);
        rdc(`DST_OFS_INTCTL, 32'h05);
        chk(irq1, 1'b0);
        wr(`DST_OFS_INTCTL, 32'h1F);
        rdc(`DST_OFS_INTCTL, 32'h1F);
        chk({irq1, irq2}, 2'h2);
        wr(`DST_OFS_INTCTL, 32'h8F);
        rdc(`DST_OFS_INTCTL, 32'h8F);
        chk({irq1, irq2}, 2'h1);
        wr(`DST_OFS_INTCLR, 32'h08);
        rdc(`DST_OFS_INTCTL, 32'h87);
        chk(irq2, 1'b0);
        wr(`DST_OFS_INTCLR, 32'h07);
        rdc(`DST_OFS_INTCTL, 32'h80);
        wr(`DST_OFS_INTCTL, 32'h00);
        wr(`DST_OFS_CNT1, 32'h2);
        wr(`DST_OFS_RCAP1, 32'h2);
        wr(`DST_OFS_RCAP2, 32'h2);
        wr(`DST_OFS_PRESCALE, 32'h0);
        wr(`DST_OFS_MODE, 32'h50);
        @(posedge clk);
        chk({pa_oe, pa_o}, 2'h3);
        wr(`DST_OFS_CLKSEL, 32'h1);
        tog(64);
        t0 = tg;
        chk(t0 > 8, 1'b1);
        wr(`DST_OFS_PRESCALE, 32'h3);
        tog(64);
        chk(tg * 4 >= t0 - 4 && tg * 4 <= t0 + 4, 1'b1);
        wr(`DST_OFS_CLKSEL, 32'h0);
        tog(20);
        chk(tg, 0);
        wr(`DST_OFS_MODE, 32'h10);
        rdc(`DST_OFS_MODE, 32'h10);
        chk(pa_o, 1'b0);
        wr(`DST_OFS_MODE, 32'h50);
        chk(pa_o, 1'b1);
        wr(`DST_OFS_MODE, 32'h00);
        wr(`DST_OFS_CLKSEL, 32'h1);
        tog(30);
        chk({pa_oe, tg[7:0]}, 9'h0);
        wr(`DST_OFS_CLKSEL, 32'h0);
        pin(1, 1);
        wr(`DST_OFS_CNT1, 32'h10);
        wr(`DST_OFS_CLKSEL, 32'h2);
        repeat (3)
        begin
            pin(1, 0);
            pin(1, 1);
        end
        wr(`DST_OFS_MODE, 32'h08);
        pin(1, 0);
        pin(1, 1);
        wr(`DST_OFS_CLKSEL, 32'h0);
        rdc(`DST_OFS_CNT1, 32'h0C);
        pin(1, 0);
        wr(`DST_OFS_CNT1, 32'h100);
        wr(`DST_OFS_CLKSEL, 32'h3);
        repeat (20) @(posedge clk);
        rdc(`DST_OFS_CNT1, 32'h100);
        pin(1, 1);
        pin(1, 0);
        wr(`DST_OFS_CLKSEL, 32'h0);
        rd(`DST_OFS_CNT1);
        chk(rv < 32'h100 && rv > 32'hE0, 1'b1);
        wr(`DST_OFS_CNT1, 32'h50);
        wr(`DST_OFS_CLKSEL, 32'h4);
        repeat (4)
        begin
            slow <= 1'b1;
            repeat (4) @(posedge clk);
            slow <= 1'b0;
            repeat (4) @(posedge clk);
        end
        repeat (6) @(posedge clk);
        wr(`DST_OFS_CLKSEL, 32'h0);
        rdc(`DST_OFS_CNT1, 32'h4C);
        wr(`DST_OFS_MODE, 32'h15);
        wr(`DST_OFS_CNT1, 32'h1234);
        chk(pa_oe, 1'b0);
        pin(0, 1);
        rdc(`DST_OFS_CNT1, 32'hFFFF);
        wr(`DST_OFS_CNT1, 32'h1234);
        pin(0, 0);
        rdc(`DST_OFS_CNT1, 32'h1234);
        wr(`DST_OFS_MODE, 32'h21);
        pin(1, 1);
        wr(`DST_OFS_CNT1, 32'h0777);
        pin(1, 0);
        rdc(`DST_OFS_CNT1, 32'hFFFF);
        wr(`DST_OFS_MODE, 32'h23);
        wr(`DST_OFS_CNT2, 32'h55);
        pin(1, 1);
        pin(1, 0);
        rdc(`DST_OFS_CNT2, 32'hFFFF);
        wr(`DST_OFS_MODE, 32'h03);
        wr(`DST_OFS_CLKSEL, 32'h10);
        wr(`DST_OFS_CNT2, 32'h55);
        pin(1, 1);
        pin(1, 0);
        rdc(`DST_OFS_CNT2, 32'h55);
        wr(`DST_OFS_CLKSEL, 32'h0);
        wr(`DST_OFS_MODE, 32'h22);
        wr(`DST_OFS_CNT1, 32'h0777);
        pin(1, 1);
        pin(1, 0);
        rdc(`DST_OFS_CNT1, 32'h0777);
        rdc(`DST_OFS_CNT2, 32'h55);
        // mode 3: counter 2 on the prescaled clock reloads from its register
        wr(`DST_OFS_INTCLR, 32'h0F);
        wr(`DST_OFS_INTCTL, 32'h80);
        wr(`DST_OFS_RCAP2, 32'h40);
        wr(`DST_OFS_CNT2, 32'h0);
        wr(`DST_OFS_CLKSEL, 32'h08);
        repeat (14) @(posedge clk);
        wr(`DST_OFS_CLKSEL, 32'h0);
        rd(`DST_OFS_CNT2);
        chk(rv <= 32'h40 && rv > 32'h30, 1'b1);
        rdc(`DST_OFS_INTCTL, 32'h88);
        chk({irq1, irq2}, 2'h1);
        wr(`DST_OFS_CNT1, 32'h0ABC);
        @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        rdc(`DST_OFS_CNT1, 32'h0ABC);
        rdc(`DST_OFS_MODE, 32'h0);
        complete_run;
    end
endmodule
